// File: common/gfp_cfg.svh
// Purpose: constants for the pin function and host port block
// Assumes: included by bare name
// Notes: counts are in core_clk cycles
`ifndef GFP_CFG_SVH
`define GFP_CFG_SVH
`define GFP_NPIN 5
`define GFP_NRAIL 4
`define GFP_POL_RST 6'h00
`define GFP_POL_BUS_MASK 6'h30
`define GFP_LSB_PIN 2
`define GFP_CRC_POLY 8'h07
`define GFP_DET_WIN 16'h0400
`define GFP_REG_POL 8'h00
`define GFP_REG_RAIL 8'h01
`endif

// File: common/gfp_pkg.sv
// Purpose: types for the pin function and host port block
// Assumes: nothing
// Notes: rail 0 is the standby regulator, rails 1..3 the buck channels
`default_nettype none
package gfp_pkg;
	typedef enum logic [2:0]
	{
		GFP_FN_IN = 3'b000,
		GFP_FN_OUT = 3'b001,
		GFP_FN_RAIL_EN = 3'b010,
		GFP_FN_PGOOD = 3'b011,
		GFP_FN_IND = 3'b100,
		GFP_FN_CLK_IN = 3'b101,
		GFP_FN_CLK_OUT = 3'b110,
		GFP_FN_SYNC_OUT = 3'b111
	} gfp_fn_t;
	typedef enum logic [3:0]
	{
		GFP_IND_OC_F1 = 4'h0, GFP_IND_OC_F2 = 4'h1, GFP_IND_OC_F3 = 4'h2,
		GFP_IND_OC_W1 = 4'h3, GFP_IND_OC_W2 = 4'h4, GFP_IND_OC_W3 = 4'h5,
		GFP_IND_OV_F1 = 4'h6, GFP_IND_OV_F2 = 4'h7, GFP_IND_OV_F3 = 4'h8,
		GFP_IND_UV_F = 4'h9, GFP_IND_UV_W = 4'ha,
		GFP_IND_OT_F = 4'hb, GFP_IND_OT_W = 4'hc
	} gfp_ind_t;
	typedef struct packed
	{
		gfp_fn_t fn;
		logic [3:0] rail_assign;
		gfp_ind_t ind_sel;
	} gfp_pin_cfg_t;
	typedef struct packed
	{
		logic [2:0] oc_fault;
		logic [2:0] oc_warn;
		logic [2:0] ov_fault;
		logic uv_fault;
		logic uv_warn;
		logic ot_fault;
		logic ot_warn;
	} gfp_events_t;
	typedef enum logic [1:0]
	{
		GFP_CK_INT = 2'b00,
		GFP_CK_CHECK = 2'b01,
		GFP_CK_EXT = 2'b10
	} gfp_ck_t;
endpackage : gfp_pkg
`default_nettype wire

// File: hw/gfp_top.sv
// Purpose: pin function mux, polarity, rail enables, host address and PEC
// Assumes: host bytes arrive already deserialised as strobes
// Notes: clock switching is a decision flag; the mux itself lives elsewhere
//
// Function
// - A pin may be set as external clock input besides plain in/out.
// - Pin function comes from OTP bits or host-written values.
// - Polarity bits zero to four invert each pin's level, input or output; bit five drives no pin.
// - In host-bus mode writes to polarity bits five and four are ignored.
// - Rail-enable pin turns its rails on while asserted; deasserting it leaves on any rail the host or another pin enables.
// - Rail assignment is one channel, standby regulator, or any mix.
// - Host commands can also enable each rail, and disable it only when no rail-enable pin asserts it.
// - Power-good pin asserts only when all its rails are in regulation.
// - Per-rail power-good is also readable as status.
// - Indicator pin signals exactly one chosen fault or warning.
// - With PEC on, a CRC-8 byte ends every transfer.
// - Seven-bit address comes from non-volatile memory.
// - Optionally address LSB comes from pin two's level.
// - External clock reaches both units or master forwards it.
// - Master with external clock is itself set for clock input.
// - Start internal; switch only when detector finds clock in window.
// - Master drives clock and sync outputs after config load.
`default_nettype none
`include "gfp_cfg.svh"
module gfp_top
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Pins
	input wire logic [4:0] pin_in,
	output logic [4:0] pin_out,
	output logic [4:0] pin_oe,
	// Configuration
	input wire logic cfg_from_host,
	input wire gfp_pkg::gfp_pin_cfg_t [4:0] otp_pin_cfg,
	input wire gfp_pkg::gfp_pin_cfg_t [4:0] host_pin_cfg,
	input wire logic [5:0] otp_pol,
	input wire logic host_bus_mode,
	input wire logic is_master,
	input wire logic cfg_loaded,
	input wire logic clk_ref,
	input wire logic sync_ref,
	input wire logic [15:0] freq_error,
	input wire logic freq_meas_valid,
	// Host port bytes
	input wire logic [6:0] nvm_addr,
	input wire logic addr_lsb_from_pin,
	input wire logic pec_enable,
	input wire logic rx_start,
	input wire logic rx_stop,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// Rails and monitors
	input wire logic [3:0] rail_good,
	input wire gfp_pkg::gfp_events_t events,
	output logic [3:0] rail_enable,
	output logic [3:0] rail_good_status,
	output logic [5:0] pin_polarity_select,
	output logic use_ext_clk,
	output logic addr_ack,
	output logic host_rd,
	output logic wr_valid,
	output logic [7:0] wr_reg,
	output logic [7:0] wr_data
);
	import gfp_pkg::*;

	logic rst_a, rst_b;
	logic [4:0] pin_act, drive_act, drive_en;
	logic [3:0] pin_rail_req, host_rail_en;
	logic [6:0] my_addr;
	logic [7:0] crc, next_crc;
	logic [1:0] byte_idx;
	logic [7:0] hold_reg, hold_data;
	logic hold_ok, addressed;
	gfp_ck_t ck_state;
	gfp_pin_cfg_t [4:0] pin_rail_assign_cfg;
	default clocking ck_main @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Reset released through two flops
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
		begin
			rst_a <= 1'b0;
			rst_b <= 1'b0;
		end
		else
		begin
			rst_a <= 1'b1;
			rst_b <= rst_a;
		end

	assign pin_rail_assign_cfg = cfg_from_host ? host_pin_cfg : otp_pin_cfg;

	// Per-pin function mux, polarity applied at the pin edge
	genvar g;
	generate
		for (g = 0; g < `GFP_NPIN; g++)
		begin : g_pin
			gfp_pin_cfg_t c;
			assign c = pin_rail_assign_cfg[g];
			assign pin_act[g] = pin_in[g] ^ pin_polarity_select[g];
			always_comb
			begin
				drive_act[g] = 1'b0;
				drive_en[g] = 1'b1;
				case (c.fn)
					GFP_FN_PGOOD: drive_act[g] =
						&(rail_good | ~c.rail_assign);
					GFP_FN_IND: drive_act[g] = events[12 - c.ind_sel];
					GFP_FN_CLK_OUT: drive_act[g] = is_master & cfg_loaded
						& clk_ref;
					GFP_FN_SYNC_OUT: drive_act[g] = is_master & cfg_loaded
						& sync_ref;
					GFP_FN_OUT: drive_act[g] = 1'b0;
					default: drive_en[g] = 1'b0;
				endcase
			end
			// Data outputs registered
			always_ff @(posedge core_clk or negedge rst_b)
				if (!rst_b)
				begin
					pin_out[g] <= 1'b0;
					pin_oe[g] <= 1'b0;
				end
				else
				begin
					pin_out[g] <= drive_act[g] ^ pin_polarity_select[g];
					pin_oe[g] <= drive_en[g] & (c.fn != GFP_FN_CLK_OUT
						&& c.fn != GFP_FN_SYNC_OUT || is_master & cfg_loaded);
				end
		end
	endgenerate

	// Rails: any rail-enable pin naming a rail, or host command
	always_comb
	begin
		pin_rail_req = 4'h0;
		for (int i = 0; i < `GFP_NPIN; i++)
			if (pin_rail_assign_cfg[i].fn == GFP_FN_RAIL_EN && pin_act[i])
				pin_rail_req = pin_rail_req
					| pin_rail_assign_cfg[i].rail_assign;
	end
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			rail_enable <= 4'h0;
			rail_good_status <= 4'h0;
		end
		else
		begin
			rail_enable <= pin_rail_req | host_rail_en;
			rail_good_status <= rail_good;
		end

	// Clock source: waits for config load, a clock-input pin 0 or 1, and frequency window
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			ck_state <= GFP_CK_INT;
		else
			case (ck_state)
				GFP_CK_INT: if (cfg_loaded && |{pin_rail_assign_cfg[0].fn
					== GFP_FN_CLK_IN, pin_rail_assign_cfg[1].fn == GFP_FN_CLK_IN})
					ck_state <= GFP_CK_CHECK;
				GFP_CK_CHECK: if (freq_meas_valid)
					ck_state <= (freq_error <= `GFP_DET_WIN) ? GFP_CK_EXT
						: GFP_CK_INT;
				GFP_CK_EXT: if (freq_meas_valid && freq_error > `GFP_DET_WIN)
					ck_state <= GFP_CK_INT;
				default: ck_state <= GFP_CK_INT;
			endcase
	assign use_ext_clk = (ck_state == GFP_CK_EXT);

	// Host address and PEC
	assign my_addr = addr_lsb_from_pin ? {nvm_addr[6:1],
		pin_act[`GFP_LSB_PIN]} : nvm_addr;
	always_comb
	begin
		next_crc = crc ^ rx_byte;
		for (int b = 0; b < 8; b++)
			next_crc = next_crc[7] ? ((next_crc << 1) ^ `GFP_CRC_POLY)
				: (next_crc << 1);
	end
	assign addr_ack = rx_valid && byte_idx == 2'd0
		&& rx_byte[7:1] == my_addr;

	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			byte_idx <= 2'd0;
			crc <= 8'h00;
			addressed <= 1'b0;
			host_rd <= 1'b0;
			hold_ok <= 1'b0;
			hold_reg <= 8'h00;
			hold_data <= 8'h00;
			wr_valid <= 1'b0;
			wr_reg <= 8'h00;
			wr_data <= 8'h00;
		end
		else
		begin
			wr_valid <= 1'b0;
			if (rx_start)
			begin
				byte_idx <= 2'd0;
				crc <= 8'h00;
				addressed <= 1'b0;
				hold_ok <= 1'b0;
			end
			else if (rx_valid)
			begin
				crc <= next_crc;
				if (byte_idx != 2'd3)
					byte_idx <= byte_idx + 2'd1;
				case (byte_idx)
					2'd0:
					begin
						addressed <= addr_ack;
						host_rd <= rx_byte[0];
					end
					2'd1: hold_reg <= rx_byte;
					2'd2:
					begin
						hold_data <= rx_byte;
						hold_ok <= addressed & ~host_rd;
					end
					default:
						if (pec_enable && hold_ok)
						begin
							wr_valid <= (next_crc == 8'h00);
							wr_reg <= hold_reg;
							wr_data <= hold_data;
							hold_ok <= 1'b0;
						end
				endcase
			end
			else if (rx_stop && hold_ok && !pec_enable)
			begin
				wr_valid <= 1'b1;
				wr_reg <= hold_reg;
				wr_data <= hold_data;
				hold_ok <= 1'b0;
			end
		end

	// Host-writable polarity
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			pin_polarity_select <= `GFP_POL_RST;
		else if (!cfg_from_host)
			pin_polarity_select <= otp_pol;
		else if (wr_valid && wr_reg == `GFP_REG_POL)
			pin_polarity_select <= host_bus_mode ? ((wr_data[5:0]
				& ~`GFP_POL_BUS_MASK) | (pin_polarity_select
				& `GFP_POL_BUS_MASK)) : wr_data[5:0];

	// Rail commands stay live even when pins run from OTP config
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			host_rail_en <= 4'h0;
		else if (wr_valid && wr_reg == `GFP_REG_RAIL)
			host_rail_en <= wr_data[3:0];

	a_start_clear: assert property (
		rx_start |=> byte_idx == 2'd0)
		else $error("byte index not cleared");
	a_wr_crc: assert property (
		wr_valid && pec_enable |-> $past(next_crc) == 8'h00)
		else $error("write with bad crc");
	a_rail_follow: assert property (
		##1 rail_enable == $past(pin_rail_req | host_rail_en))
		else $error("rail enable mismatch");
	a_good_status: assert property (
		##1 rail_good_status == $past(rail_good))
		else $error("status stale");
	a_pol_lock: assert property (
		cfg_from_host && host_bus_mode |=> $stable(pin_polarity_select[5:4]))
		else $error("bus polarity changed");
	a_ext_window: assert property (
		$rose(use_ext_clk) |-> $past(freq_error) <= `GFP_DET_WIN)
		else $error("switched outside window");
	a_ack_addr: assert property (
		addr_ack && !rx_start |=> addressed && host_rd == $past(rx_byte[0]))
		else $error("address byte not taken");
	a_pin_pol: assert property (
		##1 pin_out == $past(drive_act ^ pin_polarity_select[4:0]))
		else $error("pin polarity wrong");
	c_write: cover property (wr_valid);
	c_ext: cover property (use_ext_clk);
	c_ack: cover property (addr_ack);
endmodule : gfp_top
`default_nettype wire

// File: sim/gfp_host.sv
// Purpose: host model that hands framed bytes to the port as strobes
// Assumes: bytes already deserialised; driven on falling edges
// Notes: CRC-8 poly 0x07, init 0x00; bad flips the check byte's lsb
`default_nettype none
module gfp_host
(
	// Clock
	input wire logic core_clk,
	// Byte strobes
	output logic rx_start,
	output logic rx_stop,
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] crc;
	initial
	begin
		{rx_start, rx_stop, rx_valid} = 3'b000;
		rx_byte = 8'h5a;
	end
	function automatic logic [7:0] nx(input logic [7:0] c, b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++)
			r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction : nx
	task put(input logic [7:0] b);
		rx_valid = 1'b1;
		rx_byte = b;
		crc = nx(crc, b);
		@(negedge core_clk);
	endtask : put
	// Address first, then register, then data, back to back
	task send(input logic [7:0] a, r, d, input logic pec, bad);
		crc = 8'h00;
		@(negedge core_clk);
		rx_start = 1'b1;
		@(negedge core_clk);
		rx_start = 1'b0;
		put(a);
		put(r);
		put(d);
		if (pec)
			put(crc ^ {7'h00, bad});
		rx_valid = 1'b0;
		// Released byte lines show the inverse, never a stale copy
		rx_byte = ~rx_byte;
		rx_stop = 1'b1;
		@(negedge core_clk);
		rx_stop = 1'b0;
	endtask : send
endmodule : gfp_host
`default_nettype wire

// File: sim/tb_gfp_top.sv
// Purpose: self-checking bench for the pin function and host port
// Assumes: inputs change on falling edges only
// Notes: indicator bit mapping follows struct order of the event flags
`default_nettype none
module tb_gfp_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gfp_pkg::*;
	logic core_clk, rstn, cfg_from_host, host_bus_mode, is_master;
	logic cfg_loaded, clk_ref, sync_ref, freq_meas_valid, pec_enable;
	logic addr_lsb_from_pin, rx_start, rx_stop, rx_valid, addr_ack;
	logic host_rd, wr_valid, use_ext_clk;
	logic [4:0] pin_in, pin_out, pin_oe;
	logic [5:0] otp_pol, pin_polarity_select;
	logic [15:0] freq_error;
	logic [6:0] nvm_addr;
	logic [7:0] rx_byte, wr_reg, wr_data;
	logic [3:0] rail_good, rail_enable, rail_good_status;
	gfp_pin_cfg_t [4:0] otp_pin_cfg, host_pin_cfg;
	gfp_events_t events;
	int mismatches, n_compared, n_wr, n_ack, cycles;
	gfp_top DUT (.*);
	gfp_host host (.core_clk, .rx_start, .rx_stop, .rx_valid, .rx_byte);
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (wr_valid === 1'b1)
			n_wr++;
		if (addr_ack === 1'b1)
			n_ack++;
		if (cycles == 4000)
		begin
			mismatches++;
			close_out;
		end
	end
	task chk(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask : idle
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task t_addr;
		int w, a;
		w = n_wr;
		a = n_ack;
		host.send({7'h10, 1'b1}, 8'h01, 8'h0f, 1'b0, 1'b0);
		chk("host_rd", host_rd, 16'h0001);
		host.send(8'h40, 8'h01, 8'h0f, 1'b0, 1'b0);
		host.send({7'h10, 1'b0}, 8'h01, 8'h0a, 1'b0, 1'b0);
		idle(2);
		chk("rail_cmd", rail_enable, 16'h000a);
		chk("wr_reg", wr_reg, 16'h0001);
		chk("n_wr", 16'(n_wr - w), 16'h0001);
		chk("n_ack", 16'(n_ack - a), 16'h0002);
		chk("wr_data", wr_data, 16'h000a);
		$display("test address done");
	endtask : t_addr
	task t_pol;
		cfg_from_host = 1'b1;
		host_bus_mode = 1'b1;
		host.send(8'h20, 8'h00, 8'h3f, 1'b0, 1'b0);
		idle(2);
		chk("pol_bus", pin_polarity_select, 16'h000f);
		host_pin_cfg[0] = '{GFP_FN_RAIL_EN, 4'h1, GFP_IND_OC_F1};
		idle(3);
		chk("rail_host_cfg", rail_enable, 16'h000b);
		host_bus_mode = 1'b0;
		pec_enable = 1'b1;
		host.send(8'h20, 8'h00, 8'h2a, 1'b1, 1'b1);
		idle(2);
		chk("pol_bad", pin_polarity_select, 16'h000f);
		host.send(8'h20, 8'h00, 8'h3f, 1'b1, 1'b0);
		idle(2);
		chk("pol_pec", pin_polarity_select, 16'h003f);
		{pec_enable, cfg_from_host} = 2'b00;
		$display("test polarity done");
	endtask : t_pol
	task t_lsb;
		addr_lsb_from_pin = 1'b1;
		pin_in = 5'h04;
		host.send(8'h20, 8'h01, 8'h03, 1'b0, 1'b0);
		host.send(8'h22, 8'h01, 8'h05, 1'b0, 1'b0);
		idle(2);
		chk("rail_lsb", rail_enable, 16'h0005);
		addr_lsb_from_pin = 1'b0;
		host.send(8'h20, 8'h01, 8'h00, 1'b0, 1'b0);
		$display("test address pin done");
	endtask : t_lsb
	task t_pins;
		otp_pin_cfg[0] = '{GFP_FN_RAIL_EN, 4'hb, GFP_IND_OC_F1};
		otp_pin_cfg[1] = '{GFP_FN_PGOOD, 4'h6, GFP_IND_OC_F1};
		otp_pin_cfg[2] = '{GFP_FN_OUT, 4'h0, GFP_IND_OC_F1};
		otp_pol = 6'h01;
		pin_in = 5'h00;
		rail_good = 4'h6;
		idle(3);
		chk("rail_pin", rail_enable, 16'h000b);
		chk("pgood", {pin_oe[1], pin_out[1]}, 16'h0003);
		chk("status", rail_good_status, 16'h0006);
		chk("out_fn", {pin_oe[2], pin_out[2]}, 16'h0002);
		pin_in = 5'h01;
		rail_good = 4'h4;
		idle(3);
		chk("rail_off", rail_enable, 16'h0000);
		chk("pgood_lo", pin_out[1], 16'h0000);
		otp_pol = 6'h00;
		for (int s = 0; s < 13; s++)
		begin
			otp_pin_cfg[4] = '{GFP_FN_IND, 4'h0, gfp_ind_t'(s)};
			events = gfp_events_t'(13'h0001 << (12 - s));
			idle(3);
			chk("ind_on", pin_out[4], 16'h0001);
			events = ~events;
			idle(3);
			chk("ind_off", pin_out[4], 16'h0000);
		end
		$display("test pin functions done");
	endtask : t_pins
	task t_clk;
		otp_pin_cfg[1] = '{GFP_FN_CLK_IN, 4'h0, GFP_IND_OC_F1};
		otp_pin_cfg[2] = '{GFP_FN_CLK_IN, 4'h0, GFP_IND_OC_F1};
		otp_pin_cfg[3] = '{GFP_FN_CLK_OUT, 4'h0, GFP_IND_OC_F1};
		otp_pin_cfg[4] = '{GFP_FN_SYNC_OUT, 4'h0, GFP_IND_OC_F1};
		{is_master, clk_ref, sync_ref} = 3'b110;
		freq_error = 16'h0800;
		idle(3);
		chk("oe_early", pin_oe[3], 16'h0000);
		chk("clk_in_oe", pin_oe[2:1], 16'h0000);
		cfg_loaded = 1'b1;
		idle(1);
		freq_meas_valid = 1'b1;
		idle(1);
		freq_meas_valid = 1'b0;
		idle(3);
		chk("ext_out", use_ext_clk, 16'h0000);
		freq_error = 16'h0010;
		freq_meas_valid = 1'b1;
		idle(1);
		freq_meas_valid = 1'b0;
		idle(3);
		chk("ext_in", use_ext_clk, 16'h0001);
		chk("fwd", {pin_oe[4:3], pin_out[4:3]}, 16'h000d);
		{clk_ref, sync_ref} = 2'b01;
		idle(3);
		chk("fwd2", pin_out[4:3], 16'h0002);
		$display("test clock done");
	endtask : t_clk
	initial
	begin
		{rstn, cfg_from_host, host_bus_mode, is_master} = 4'h0;
		{cfg_loaded, clk_ref, sync_ref, freq_meas_valid} = 4'h0;
		{addr_lsb_from_pin, pec_enable, pin_in, otp_pol} = 13'h0000;
		{freq_error, rail_good, events} = 33'h0_0000_0000;
		nvm_addr = 7'h10;
		otp_pin_cfg = '0;
		host_pin_cfg = '0;
		mismatches = 0;
		n_compared = 0;
		n_wr = 0;
		n_ack = 0;
		cycles = 0;
		repeat (8) @(negedge core_clk);
		rstn = 1'b1;
		idle(3);
		t_addr;
		t_pol;
		t_lsb;
		t_pins;
		t_clk;
		close_out;
	end
endmodule : tb_gfp_top
`default_nettype wire
